// ---- design/gbi_fifo.sv ----
// Purpose: Small receive buffer between the bus acceptor and the user
// Assumes: Depth of at least two
// Notes: Full drops wr.ready, which stalls the acceptor handshake
`timescale 1ns/1ps
`default_nettype none

module gbi_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	gbi_stream_if.snk wr,
	gbi_stream_if.src rd
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic push, pop;

	assign wr.ready = (cnt_reg != FULL);
	assign rd.valid = (cnt_reg != '0);
	assign rd.data = mem[rp_reg];
	assign push = wr.valid & wr.ready;
	assign pop = rd.valid & rd.ready;

	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wp_next = (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
		end
		if (pop) begin
			rp_next = (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end

endmodule // gbi_fifo

`default_nettype wire

// ---- design/gbi_instr_port.sv ----
// Purpose: Instrument side of the parallel instrument bus and serial input
// Assumes: All pins synchronous to clk; wire level low means asserted
// Notes: Open-drain pins use out, oe_n pairs; oe_n low pulls the wire low
`timescale 1ns/1ps
`default_nettype none

module gbi_instr_port #(
	parameter int KEY_W = 8,
	parameter int STAT_W = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [4:0] my_addr,
	input wire logic [7:0] dio_in,
	output logic [7:0] dio_out,
	output logic [7:0] dio_oe_n,
	input wire logic dav_in,
	output logic dav_out,
	output logic dav_oe_n,
	input wire logic nrfd_in,
	output logic nrfd_out,
	output logic nrfd_oe_n,
	input wire logic ndac_in,
	output logic ndac_out,
	output logic ndac_oe_n,
	input wire logic eoi_in,
	output logic eoi_out,
	output logic eoi_oe_n,
	input wire logic atn_n,
	input wire logic ifc_n,
	input wire logic ren_n,
	input wire logic port_sel,
	input wire logic rs_valid,
	input wire logic [7:0] rs_data,
	input wire logic rs_end,
	output logic rs_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	output logic tx_ready,
	input wire logic [7:0] status_byte,
	input wire logic [KEY_W-1:0] key_in,
	input wire logic local_key,
	output logic [KEY_W-1:0] key_out,
	input wire logic [STAT_W-1:0] stat_in,
	output logic [STAT_W-1:0] stat_out,
	output logic remote,
	output logic talk_addr,
	output logic listen_addr,
	output logic spoll_active,
	output logic dev_clear
);

	// ****************************************
	// Wire levels to asserted levels
	// ****************************************
	logic atn, ifc, ren, dav_a;
	logic [7:0] bus_byte;
	logic [6:0] cmd;

	assign atn = ~atn_n;
	assign ifc = ~ifc_n;
	assign ren = ~ren_n;
	assign dav_a = ~dav_in;
	assign bus_byte = ~dio_in;
	assign cmd = bus_byte[6:0];

	// ****************************************
	// Addressed state
	// ****************************************
	logic talk_reg, talk_next;
	logic lstn_reg, lstn_next;
	logic spe_reg, spe_next;
	logic stb_reg, stb_next;
	logic rem_reg, rem_next;
	logic llo_reg, llo_next;
	logic clr_reg, clr_next;
	logic [KEY_W-1:0] key_reg, key_next;
	logic [STAT_W-1:0] stat_reg, stat_next;

	// ****************************************
	// Acceptor handshake
	// ****************************************
	gbi_pkg::gbi_ah_e ah_reg, ah_next;
	logic ah_active, ah_ok, take, cmd_take, data_take;
	gbi_stream_if #(.W(gbi_pkg::WORD_W)) rx_in ();
	gbi_stream_if #(.W(gbi_pkg::WORD_W)) rx_out ();

	// Commands are heard by everyone under attention; data only when listening
	assign ah_active = atn | lstn_reg;
	// Ready is withdrawn without buffer room, so a slow user stalls the talker
	assign ah_ok = atn | (rx_in.ready & ~port_sel);
	assign take = (ah_reg == gbi_pkg::AH_RDY) & ah_ok & dav_a;
	assign cmd_take = take & atn;
	assign data_take = take & ~atn & lstn_reg;

	always_comb begin
		ah_next = ah_reg;
		case (ah_reg)
			gbi_pkg::AH_IDLE: begin
				if (ah_ok) begin
					ah_next = gbi_pkg::AH_RDY;
				end
			end
			gbi_pkg::AH_RDY: begin
				if (dav_a) begin
					ah_next = gbi_pkg::AH_ACC;
				end
			end
			gbi_pkg::AH_ACC: begin
				if (!dav_a) begin
					ah_next = gbi_pkg::AH_IDLE;
				end
			end
			default: ah_next = gbi_pkg::AH_IDLE;
		endcase
		if (!ah_active || ifc || (ah_reg == gbi_pkg::AH_RDY && !ah_ok)) begin
			ah_next = gbi_pkg::AH_IDLE;
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	logic is_mla, is_mta, is_ota;

	assign is_mla = (cmd == {gbi_pkg::GRP_LISTEN, my_addr});
	assign is_mta = (cmd == {gbi_pkg::GRP_TALK, my_addr});
	assign is_ota = (cmd[6:5] == gbi_pkg::GRP_TALK) & ~is_mta & (cmd != gbi_pkg::CMD_UNT);

	// ****************************************
	// Talker, listener, remote and clear state
	// ****************************************
	logic stb_sent;

	always_comb begin
		talk_next = talk_reg;
		lstn_next = lstn_reg;
		spe_next = spe_reg;
		stb_next = stb_reg;
		rem_next = rem_reg;
		llo_next = llo_reg;
		clr_next = 1'b0;
		if (cmd_take) begin
			if (is_mta) begin
				talk_next = 1'b1;
				lstn_next = 1'b0;
				stb_next = spe_reg;
			end
			if (is_mla) begin
				lstn_next = 1'b1;
				talk_next = 1'b0;
				rem_next = ren;
			end
			if (is_ota || cmd == gbi_pkg::CMD_UNT) begin
				talk_next = 1'b0;
			end
			if (cmd == gbi_pkg::CMD_UNL) begin
				lstn_next = 1'b0;
			end
			if (cmd == gbi_pkg::CMD_SPE) begin
				spe_next = 1'b1;
				stb_next = 1'b1;
			end
			if (cmd == gbi_pkg::CMD_SPD) begin
				spe_next = 1'b0;
				stb_next = 1'b0;
			end
			// Selected clear only counts when addressed to listen
			if (cmd == gbi_pkg::CMD_DCL || (cmd == gbi_pkg::CMD_SDC && lstn_reg)) begin
				clr_next = 1'b1;
			end
			if (cmd == gbi_pkg::CMD_GTL && lstn_reg) begin
				rem_next = 1'b0;
			end
			if (cmd == gbi_pkg::CMD_LLO && ren) begin
				llo_next = 1'b1;
			end
		end
		if (stb_sent) begin
			stb_next = 1'b0;
		end
		// Lockout blocks the local key, so remote can be forced to stay
		if (local_key && rem_reg && !llo_reg) begin
			rem_next = 1'b0;
		end
		if (!ren) begin
			rem_next = 1'b0;
			llo_next = 1'b0;
		end
		if (ifc) begin
			talk_next = 1'b0;
			lstn_next = 1'b0;
			spe_next = 1'b0;
			stb_next = 1'b0;
		end
		key_next = rem_reg ? '0 : key_in;
		stat_next = stat_in;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ah_reg <= gbi_pkg::AH_IDLE;
			talk_reg <= gbi_pkg::RST_FLAG;
			lstn_reg <= gbi_pkg::RST_FLAG;
			spe_reg <= gbi_pkg::RST_FLAG;
			stb_reg <= gbi_pkg::RST_FLAG;
			rem_reg <= gbi_pkg::RST_FLAG;
			llo_reg <= gbi_pkg::RST_FLAG;
			clr_reg <= gbi_pkg::RST_FLAG;
			key_reg <= '0;
			stat_reg <= '0;
		end else begin
			ah_reg <= ah_next;
			talk_reg <= talk_next;
			lstn_reg <= lstn_next;
			spe_reg <= spe_next;
			stb_reg <= stb_next;
			rem_reg <= rem_next;
			llo_reg <= llo_next;
			clr_reg <= clr_next;
			key_reg <= key_next;
			stat_reg <= stat_next;
		end
	end

	// ****************************************
	// Receive path: bus bytes or serial bytes into the buffer
	// ****************************************
	always_comb begin
		if (port_sel) begin
			rx_in.valid = rs_valid;
			rx_in.data = {rs_end, rs_data};
		end else begin
			rx_in.valid = data_take;
			rx_in.data = {~eoi_in, bus_byte};
		end
	end
	assign rs_ready = port_sel & rx_in.ready;

	gbi_fifo #(
		.W(gbi_pkg::WORD_W),
		.DEPTH(gbi_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk(clk),
		.srst(srst),
		.wr(rx_in),
		.rd(rx_out)
	);

	assign rx_valid = rx_out.valid;
	assign rx_data = rx_out.data[7:0];
	assign rx_end = rx_out.data[8];
	assign rx_out.ready = rx_ready;

	// ****************************************
	// Transmit path: user bytes or the poll status byte
	// ****************************************
	gbi_stream_if #(.W(gbi_pkg::WORD_W)) tx_if ();
	logic talk_act, sh_dav, sh_drive;
	logic [8:0] sh_word;

	// Sourcing stops as soon as the controller takes attention back
	assign talk_act = talk_reg & ~atn;

	always_comb begin
		if (spe_reg) begin
			// Poll answer is one byte with end set; service request bit is never set
			tx_if.valid = talk_act & stb_reg;
			tx_if.data = {1'b1, status_byte[7], 1'b0, status_byte[5:0]};
		end else begin
			tx_if.valid = talk_act & tx_valid;
			tx_if.data = {tx_end, tx_data};
		end
	end
	assign stb_sent = tx_if.ready & spe_reg;
	assign tx_ready = tx_if.ready & ~spe_reg;

	gbi_src_hs u_src (
		.clk(clk),
		.srst(srst),
		.clear(ifc | ~talk_act),
		.tx(tx_if),
		.nrfd_n(nrfd_in),
		.ndac_n(ndac_in),
		.dav(sh_dav),
		.drive(sh_drive),
		.word(sh_word)
	);

	// ****************************************
	// Pin drive
	// ****************************************
	assign dio_out = '0;
	assign dio_oe_n = ~({8{sh_drive}} & sh_word[7:0]);
	assign eoi_out = 1'b0;
	assign eoi_oe_n = ~(sh_drive & sh_word[8]);
	assign dav_out = 1'b0;
	assign dav_oe_n = ~sh_dav;
	assign nrfd_out = 1'b0;
	assign nrfd_oe_n = ~(ah_active & ~((ah_reg == gbi_pkg::AH_RDY) & ah_ok));
	assign ndac_out = 1'b0;
	assign ndac_oe_n = ~(ah_active & (ah_reg != gbi_pkg::AH_ACC));

	// ****************************************
	// User outputs
	// ****************************************
	assign key_out = key_reg;
	assign stat_out = stat_reg;
	assign remote = rem_reg;
	assign talk_addr = talk_reg;
	assign listen_addr = lstn_reg;
	assign spoll_active = spe_reg;
	assign dev_clear = clr_reg;

endmodule // gbi_instr_port

`default_nettype wire

// ---- design/gbi_pkg.sv ----
// Purpose: Shared constants and types for the instrument bus port
// Assumes: 50 MHz clock, bus pins already synchronous to clk
// Notes: Bus wires are active low; asserted means the wire is pulled low

package gbi_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 20;
	// Settling time between data placed on the bus and valid asserted
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
	typedef logic [SETTLE_W-1:0] gbi_settle_t;
	localparam gbi_settle_t SETTLE_LOAD = gbi_settle_t'(SETTLE_CYC - 1);

	// ****************************************
	// Sizes
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int WORD_W = 9;
	localparam int FIFO_DEPTH = 4;

	// ****************************************
	// Bus commands, low seven bits of a byte sent under attention
	// ****************************************
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;

	// ****************************************
	// Reset values and state encodings
	// ****************************************
	localparam logic RST_FLAG = 1'b0;

	typedef enum logic [1:0] {
		AH_IDLE = 2'h0,
		AH_RDY = 2'h1,
		AH_ACC = 2'h3
	} gbi_ah_e;

	typedef enum logic [1:0] {
		SH_IDLE = 2'h0,
		SH_SETTLE = 2'h1,
		SH_DAV = 2'h3,
		SH_REL = 2'h2
	} gbi_sh_e;

endpackage

// ---- design/gbi_src_hs.sv ----
// Purpose: Source handshake for bytes sent by the addressed talker
// Assumes: Acceptors pull ready-for-data and data-accepted low as usual
// Notes: Word bit 8 is the end flag, bits 7:0 the data byte
`timescale 1ns/1ps
`default_nettype none

module gbi_src_hs (
	input wire logic clk,
	input wire logic srst,
	input wire logic clear,
	gbi_stream_if.snk tx,
	input wire logic nrfd_n,
	input wire logic ndac_n,
	output logic dav,
	output logic drive,
	output logic [8:0] word
);
	gbi_pkg::gbi_sh_e st_reg, st_next;
	gbi_pkg::gbi_settle_t cnt_reg, cnt_next;
	logic [8:0] word_reg, word_next;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		word_next = word_reg;
		case (st_reg)
			gbi_pkg::SH_IDLE: begin
				if (tx.valid) begin
					word_next = tx.data;
					cnt_next = gbi_pkg::SETTLE_LOAD;
					st_next = gbi_pkg::SH_SETTLE;
				end
			end
			gbi_pkg::SH_SETTLE: begin
				// Valid waits for settling and for every acceptor ready
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (nrfd_n) begin
					st_next = gbi_pkg::SH_DAV;
				end
			end
			gbi_pkg::SH_DAV: begin
				if (ndac_n) begin
					st_next = gbi_pkg::SH_REL;
				end
			end
			gbi_pkg::SH_REL: st_next = gbi_pkg::SH_IDLE;
			default: st_next = gbi_pkg::SH_IDLE;
		endcase
		if (clear) begin
			st_next = gbi_pkg::SH_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= gbi_pkg::SH_IDLE;
			cnt_reg <= '0;
			word_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			word_reg <= word_next;
		end
	end

	// The word is consumed only once all acceptors have taken it
	assign tx.ready = (st_reg == gbi_pkg::SH_DAV) & ndac_n & ~clear;
	assign dav = (st_reg == gbi_pkg::SH_DAV);
	assign drive = (st_reg != gbi_pkg::SH_IDLE);
	assign word = word_reg;

endmodule // gbi_src_hs

`default_nettype wire

// ---- design/gbi_stream_if.sv ----
// Purpose: Valid/ready word carrier between the port's own modules
// Assumes: A word moves on a clock edge with valid and ready both high
// Notes: Data must hold while valid waits for ready
`timescale 1ns/1ps
`default_nettype none

interface gbi_stream_if #(parameter int W = 9);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface // gbi_stream_if

`default_nettype wire

// ---- dv/gbi_chk.sv ----
// Purpose: Pin-level checks on the instrument bus port
// Assumes: One clock domain, srst synchronous and active high
// Notes: Bound to every gbi_instr_port
`timescale 1ns/1ps
`default_nettype none

module gbi_chk #(
	parameter int KEY_W = 8,
	parameter int STAT_W = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] dio_oe_n,
	input wire logic [7:0] dio_out,
	input wire logic dav_out,
	input wire logic nrfd_out,
	input wire logic ndac_out,
	input wire logic eoi_out,
	input wire logic dav_in,
	input wire logic dav_oe_n,
	input wire logic nrfd_oe_n,
	input wire logic ndac_in,
	input wire logic ndac_oe_n,
	input wire logic atn_n,
	input wire logic ifc_n,
	input wire logic tx_ready,
	input wire logic [KEY_W-1:0] key_in,
	input wire logic [KEY_W-1:0] key_out,
	input wire logic [STAT_W-1:0] stat_in,
	input wire logic [STAT_W-1:0] stat_out,
	input wire logic remote,
	input wire logic talk_addr,
	input wire logic listen_addr,
	input wire logic spoll_active,
	input wire logic dev_clear
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// ****************************************
	// Handshake steps
	// ****************************************
	sequence s_take;
		!dav_in && nrfd_oe_n && !ndac_oe_n && (!atn_n || listen_addr) && ifc_n;
	endsequence
	sequence s_accept;
		!nrfd_oe_n && ndac_oe_n;
	endsequence
	sequence s_src_done;
		!dav_oe_n && ndac_in && atn_n && ifc_n;
	endsequence

	a_take_accept: assert property (s_take |=> s_accept)
		else $error("acceptor missed a byte");
	a_dav_release: assert property (s_src_done |=> dav_oe_n)
		else $error("data valid held after accept");
	a_ready_pulse: assert property (s_src_done ##0 !spoll_active |-> tx_ready)
		else $error("no ready pulse on accept");
	a_data_hold: assert property (!dav_oe_n && !$past(dav_oe_n) |-> $stable(dio_oe_n))
		else $error("data moved under valid");
	a_poll_quiet: assert property (spoll_active |-> !tx_ready)
		else $error("user byte taken in poll");
	a_ifc_idle: assert property (!ifc_n |=> !talk_addr && !listen_addr && dav_oe_n)
		else $error("interface clear ignored");
	a_one_role: assert property (!(talk_addr && listen_addr))
		else $error("talker and listener at once");
	a_stat_copy: assert property (!$past(srst) |-> stat_out == $past(stat_in))
		else $error("status output wrong");
	a_key_lock: assert property (remote && $past(remote) |-> key_out == '0)
		else $error("panel key passed in remote");
	a_key_pass: assert property (!remote && !$past(remote) && !$past(srst)
		|-> key_out == $past(key_in))
		else $error("panel key lost in local");
	a_clear_pulse: assert property (dev_clear |=> !dev_clear)
		else $error("device clear longer than a cycle");
	a_pins_low: assert property (dio_out == '0 && !dav_out && !nrfd_out && !ndac_out
		&& !eoi_out) else $error("open-drain pin driven high");
endmodule // gbi_chk

bind gbi_instr_port gbi_chk #(.KEY_W(KEY_W), .STAT_W(STAT_W)) u_gbi_chk (.clk, .srst,
	.dio_oe_n, .dav_in, .dav_oe_n, .nrfd_oe_n, .ndac_in, .ndac_oe_n, .atn_n, .ifc_n,
	.tx_ready, .key_in, .key_out, .stat_in, .stat_out, .remote, .talk_addr, .listen_addr,
	.spoll_active, .dev_clear, .dio_out, .dav_out, .nrfd_out, .ndac_out, .eoi_out);

`default_nettype wire

// ---- dv/gbi_host.sv ----
// Purpose: Bus controller model on the far side of the port
// Assumes: Wires resolved by the bench; 1 = released
// Notes: Random pauses make it answer both promptly and slowly
`timescale 1ns/1ps
`default_nettype none

module gbi_host (
	input wire logic clk,
	input wire logic [7:0] dio_w,
	input wire logic dav_w,
	input wire logic nrfd_w,
	input wire logic ndac_w,
	input wire logic eoi_w,
	output logic [7:0] h_dio,
	output logic h_dav,
	output logic h_nrfd,
	output logic h_ndac,
	output logic h_eoi,
	output logic atn_n,
	output logic ifc_n,
	output logic ren_n
);
	initial begin
		h_dio = 8'hff;
		h_dav = 1'b1;
		h_nrfd = 1'b1;
		h_ndac = 1'b0;
		h_eoi = 1'b1;
		atn_n = 1'b1;
		ifc_n = 1'b1;
		ren_n = 1'b1; // Remote needs ren pulled by the host
	end

	// Source one byte, command when atn is set
	task automatic put(input logic atn, input logic [7:0] b, input logic e);
		int i;
		@(posedge clk);
		atn_n <= !atn;
		h_ndac <= 1'b1;
		h_dio <= ~b;
		h_eoi <= !e;
		repeat ($urandom_range(2, 5)) @(posedge clk);
		for (i = 0; i < 300 && nrfd_w !== 1'b1; i++) @(posedge clk);
		h_dav <= 1'b0;
		for (i = 0; i < 300 && ndac_w !== 1'b1; i++) @(posedge clk);
		h_dav <= 1'b1;
		h_dio <= 8'hff; // Released lines float up to the pull-up level
		h_eoi <= 1'b1;
	endtask

	// Accept one byte from the addressed talker
	task automatic get(output logic [7:0] b, output logic e);
		int i;
		@(posedge clk);
		atn_n <= 1'b1;
		h_ndac <= 1'b0;
		h_nrfd <= 1'b1;
		for (i = 0; i < 400 && dav_w !== 1'b0; i++) @(posedge clk);
		b = ~dio_w;
		e = !eoi_w;
		h_nrfd <= 1'b0;
		repeat ($urandom_range(0, 3)) @(posedge clk);
		h_ndac <= 1'b1;
		for (i = 0; i < 50 && dav_w !== 1'b1; i++) @(posedge clk);
		h_ndac <= 1'b0;
		h_nrfd <= 1'b1;
	endtask
endmodule // gbi_host

`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the instrument bus port
// Assumes: gbi_host plays the bus controller
// Notes: Random bytes from a fixed seed, commands written by hand
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] my_addr = 5'h05;
	logic port_sel = 1'b0;
	logic rs_valid = 1'b0;
	logic rs_end = 1'b0;
	logic rx_ready = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_end = 1'b0;
	logic local_key = 1'b0;
	logic [7:0] rs_data = 8'h00;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] status_byte = 8'h00;
	logic [7:0] key_in = 8'h00;
	logic [3:0] stat_in = 4'h0;
	logic [3:0] stat_out;
	logic [7:0] dio_oe_n, h_dio, dio_w, rx_data, key_out, b;
	logic dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n, h_dav, h_nrfd, h_ndac, h_eoi, e;
	logic dav_w, nrfd_w, ndac_w, eoi_w, atn_n, ifc_n, ren_n, rs_ready, rx_valid, rx_end;
	logic tx_ready, remote, talk_addr, listen_addr, spoll_active, dev_clear;
	logic [8:0] expq[$];
	logic [8:0] rxq[$];
	int n_errors = 0;
	int num_checks = 0;
	int n_clr = 0;

	always #10 clk = ~clk;
	// Open-drain lines: any party pulling makes the wire low
	assign dio_w = dio_oe_n & h_dio;
	assign dav_w = dav_oe_n & h_dav;
	assign nrfd_w = nrfd_oe_n & h_nrfd;
	assign ndac_w = ndac_oe_n & h_ndac;
	assign eoi_w = eoi_oe_n & h_eoi;

	gbi_instr_port u_gbi_instr_port (.clk, .srst, .my_addr, .dio_in(dio_w), .dio_out(),
		.dio_oe_n, .dav_in(dav_w), .dav_out(), .dav_oe_n, .nrfd_in(nrfd_w), .nrfd_out(),
		.nrfd_oe_n, .ndac_in(ndac_w), .ndac_out(), .ndac_oe_n, .eoi_in(eoi_w), .eoi_out(),
		.eoi_oe_n, .atn_n, .ifc_n, .ren_n, .port_sel, .rs_valid, .rs_data, .rs_end,
		.rs_ready, .rx_valid, .rx_data, .rx_end, .rx_ready, .tx_valid, .tx_data, .tx_end,
		.tx_ready, .status_byte, .key_in, .local_key, .key_out, .stat_in, .stat_out,
		.remote, .talk_addr, .listen_addr, .spoll_active, .dev_clear);
	gbi_host u_host (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .h_dio, .h_dav,
		.h_nrfd, .h_ndac, .h_eoi, .atn_n, .ifc_n, .ren_n);

	// Random reader stalls let the buffer fill and hold ready-for-data
	always @(posedge clk) begin
		rx_ready <= 1'($urandom_range(0, 1));
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back({rx_end, rx_data});
		if (dev_clear === 1'b1)
			n_clr++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
			n_errors++;
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] c);
		u_host.put(1'b1, c, 1'b0);
		repeat (3) @(posedge clk);
	endtask

	task automatic cmp_rx();
		int i;
		for (i = 0; i < 300 && rxq.size() < expq.size(); i++) @(posedge clk);
		chk(16'(rxq.size()), 16'(expq.size()), "rx count");
		while (rxq.size() > 0 && expq.size() > 0)
			chk(16'(rxq.pop_front()), 16'(expq.pop_front()), "rx word");
		rxq.delete();
		expq.delete();
	endtask

	task automatic send_tx(input logic [7:0] d, input logic last);
		int i;
		i = 0;
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		tx_end <= last;
		do @(posedge clk); while (tx_ready !== 1'b1 && ++i < 400);
		tx_valid <= 1'b0;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	initial begin
		int i;
		int j;
		logic [7:0] v;
		void'($urandom(32'h6c6d));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'({remote, talk_addr, listen_addr, dav_oe_n}), 16'h1, "reset");
		for (i = 0; i < 6; i++) begin
			v = 8'($urandom);
			@(posedge clk);
			stat_in <= v[3:0];
			@(posedge clk);
			#1;
			chk(16'(stat_out), 16'(v[3:0]), "status");
		end
		@(posedge clk);
		u_host.ren_n <= 1'b0;
		cmd(8'h20 | {3'h0, my_addr});
		chk(16'({remote, listen_addr, talk_addr}), 16'h6, "listen");
		@(posedge clk);
		key_in <= 8'($urandom);
		repeat (2) @(posedge clk);
		#1;
		chk(16'(key_out), 16'h0, "keys remote");
		@(posedge clk);
		local_key <= 1'b1;
		repeat (2) @(posedge clk);
		local_key <= 1'b0;
		v = 8'($urandom);
		key_in <= v;
		repeat (2) @(posedge clk);
		#1;
		chk(16'({remote, key_out}), 16'({1'b0, v}), "keys local");
		cmd(8'h20 | {3'h0, my_addr});
		cmd(8'h11);
		@(posedge clk);
		local_key <= 1'b1;
		repeat (2) @(posedge clk);
		local_key <= 1'b0;
		chk(16'(remote), 16'h1, "lockout");
		cmd(8'h01);
		chk(16'(remote), 16'h0, "go to local");
		for (i = 0; i < 8; i++) begin
			v = 8'($urandom);
			expq.push_back({i == 7, v});
			u_host.put(1'b0, v, i == 7);
		end
		cmp_rx();
		n_clr = 0;
		cmd(8'h14);
		cmd(8'h04);
		cmd(8'h3f);
		cmd(8'h04);
		chk(16'(n_clr), 16'h2, "clears");
		chk(16'(listen_addr), 16'h0, "unlisten");
		cmd(8'h40 | {3'h0, my_addr});
		chk(16'({talk_addr, listen_addr}), 16'h2, "talk");
		for (i = 0; i < 3; i++) begin
			v = 8'($urandom);
			fork
				send_tx(v, i == 2);
				u_host.get(b, e);
			join
			chk(16'({e, b}), 16'({i == 2, v}), "talk byte");
		end
		cmd(8'h40 | {3'h0, my_addr ^ 5'h01});
		chk(16'(talk_addr), 16'h0, "other talk");
		cmd(8'h40 | {3'h0, my_addr});
		cmd(8'h5f);
		chk(16'(talk_addr), 16'h0, "untalk cmd");
		cmd(8'h20 | {3'h0, my_addr});
		chk(16'({talk_addr, listen_addr}), 16'h1, "untalk");
		v = 8'($urandom);
		@(posedge clk);
		status_byte <= v;
		cmd(8'h18);
		cmd(8'h40 | {3'h0, my_addr});
		chk(16'(spoll_active), 16'h1, "poll on");
		u_host.get(b, e);
		chk(16'({e, b}), 16'({1'b1, v & 8'hbf}), "poll byte");
		cmd(8'h19);
		chk(16'(spoll_active), 16'h0, "poll off");
		cmd(8'h20 | {3'h0, my_addr});
		@(posedge clk);
		u_host.ifc_n <= 1'b0;
		repeat (2) @(posedge clk);
		u_host.ifc_n <= 1'b1;
		#1;
		chk(16'({talk_addr, listen_addr}), 16'h0, "ifc");
		@(posedge clk);
		port_sel <= 1'b1;
		for (i = 0; i < 6; i++) begin
			v = 8'($urandom);
			expq.push_back({i == 5, v});
			j = 0;
			@(posedge clk);
			rs_valid <= 1'b1;
			rs_data <= v;
			rs_end <= i == 5;
			do @(posedge clk); while (rs_ready !== 1'b1 && ++j < 100);
			rs_valid <= 1'b0;
		end
		cmp_rx();
		end_sim();
	end
endmodule // testbench

`default_nettype wire
